// file: design/tfbs_top.sv
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "tfbs_consts.svh"
module tfbs_top (
	input  wire logic              CORE_CLK,
	input  wire logic              NRST,
	input  wire logic              HSEL,
	input  wire logic [31:0]       HADDR,
	input  wire logic [1:0]        HTRANS,
	input  wire logic              HWRITE,
	input  wire logic [2:0]        HSIZE,
	input  wire logic [31:0]       HWDATA,
	input  wire logic              HREADY,
	output logic      [31:0]       HRDATA,
	output logic                   HREADYOUT,
	output logic                   HRESP,
	input  wire tfbs_pkg::tfbs_tmr_t TMR,
	input  wire logic              T2_IRQ_EN,
	output tfbs_pkg::tfbs_out_t    BAUD,
	output logic                   T2_IRQ,
	output logic                   IRQ
);
	import tfbs_pkg::*;

	// ==========================================
	// AHB-Lite slave, zero wait states
	tfbs_phase_t             phase_q;
	tfbs_phase_t             phase_d;
	logic                    wr_q;
	logic [`TFBS_ADDR_W-1:0] wr_addr_q;
	logic [7:0]              ctrl_q;
	logic [7:0]              ctrl_d;
	logic [`TFBS_EV_W-1:0]   stat_q;
	logic [`TFBS_EV_W-1:0]   ien_q;
	logic [31:0]             rdata_q;

	// ==========================================
	// Address phase decode
	wire                    acc      = HSEL & HREADY & HTRANS[1];
	wire                    acc_rd   = acc & ~HWRITE;
	wire [`TFBS_ADDR_W-1:0] a_addr   = HADDR[`TFBS_ADDR_W-1:0];
	wire                    a_ctrl   = (a_addr == `TFBS_CTRL_OFS);
	wire                    a_stat   = (a_addr == `TFBS_STAT_OFS);
	wire                    a_ien    = (a_addr == `TFBS_IEN_OFS);

	// ==========================================
	// Data phase decode
	wire                    data_ph  = (phase_q == TFBS_DATA);
	wire                    wr_pend  = data_ph & wr_q;
	wire                    wr_ctrl  = wr_pend & (wr_addr_q == `TFBS_CTRL_OFS);
	wire                    wr_clr   = wr_pend & (wr_addr_q == `TFBS_CLR_OFS);
	wire                    wr_ien   = wr_pend & (wr_addr_q == `TFBS_IEN_OFS);
	wire [7:0]              wdat     = HWDATA[7:0];
	wire [`TFBS_EV_W-1:0]   wdat_ev  = HWDATA[`TFBS_EV_W-1:0];

	// Address and direction held only from an accepted address phase
	wire                    wr_d      = acc ? HWRITE : wr_q;
	wire [`TFBS_ADDR_W-1:0] wr_addr_d = acc ? a_addr : wr_addr_q;

	// ==========================================
	// Transfer phase tracking
	// Slave never stretches a data phase, so one cycle after each accept
	always_comb begin
		phase_d = phase_q;
		unique case (phase_q)
			TFBS_ADDR: begin
				if (acc) begin
					phase_d = TFBS_DATA;
				end
			end
			TFBS_DATA: begin
				if (!acc) begin
					phase_d = TFBS_ADDR;
				end
			end
			default: begin
				phase_d = TFBS_ADDR;
			end
		endcase
	end

	// ==========================================
	// Timer event qualification
	wire baud_use  = ctrl_q[`TFBS_RXSEL_BIT] | ctrl_q[`TFBS_TXSEL_BIT];
	wire ovf_set   = TMR.t2_ovf & ~baud_use & ~TMR.updown_mode;
	wire ovf_set_u = (TMR.t2_ovf | TMR.t2_unf) & ~baud_use & TMR.updown_mode;
	wire trig_act  = TMR.trig_fall & ctrl_q[`TFBS_PINEN_BIT] & ~baud_use & ~TMR.updown_mode;
	wire ext_tog   = (TMR.t2_ovf | TMR.t2_unf) & TMR.updown_mode;
	wire ovf_hw    = ovf_set | ovf_set_u;

	// Software write first, hardware set/toggle last so hardware wins
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d[7:3] = wdat[7:3];
		end
		if (ovf_hw) begin
			ctrl_d[`TFBS_OVF_BIT] = 1'b1;
		end
		if (trig_act) begin
			ctrl_d[`TFBS_EXT_BIT] = 1'b1;
		end else if (ext_tog) begin
			ctrl_d[`TFBS_EXT_BIT] = ~ctrl_q[`TFBS_EXT_BIT];
		end
	end

	// ==========================================
	// Sticky event status, one bit per event
	wire [`TFBS_EV_W-1:0] ev_hit;
	wire [`TFBS_EV_W-1:0] stat_d;

	assign ev_hit[`TFBS_EV_OVF] = ovf_hw;
	assign ev_hit[`TFBS_EV_EXT] = trig_act;

	genvar gi;
	generate
		for (gi = 0; gi < `TFBS_EV_W; gi++) begin : g_ev
			// Set beats a same-cycle clear so no event is lost
			assign stat_d[gi] = ev_hit[gi] | (stat_q[gi] & ~(wr_clr & wdat_ev[gi]));
		end
	endgenerate

	wire [`TFBS_EV_W-1:0] ien_d = wr_ien ? wdat_ev : ien_q;

	// ==========================================
	// Read mux
	wire [31:0] rd_ctrl = {24'h000000, ctrl_q};
	wire [31:0] rd_stat = {30'h0, stat_q};
	wire [31:0] rd_ien  = {30'h0, ien_q};

	// Unmapped and write-only offsets read as zero
	wire [31:0] rd_mux  = a_ctrl ? rd_ctrl :
		a_stat ? rd_stat :
		a_ien  ? rd_ien : 32'h00000000;

	// Data is captured at the address edge so it stands through the data phase
	wire [31:0] rdata_d = acc_rd ? rd_mux : rdata_q;

	// ==========================================
	// Bus registers
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			phase_q <= TFBS_ADDR;
		end else begin
			phase_q <= phase_d;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			wr_q <= 1'b0;
		end else begin
			wr_q <= wr_d;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			wr_addr_q <= '0;
		end else begin
			wr_addr_q <= wr_addr_d;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			rdata_q <= 32'h00000000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ==========================================
	// Control and event registers
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			ctrl_q <= `TFBS_CTRL_RST;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			stat_q <= `TFBS_EV_RST;
		end else begin
			stat_q <= stat_d;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			ien_q <= `TFBS_EV_RST;
		end else begin
			ien_q <= ien_d;
		end
	end

	// ==========================================
	// Baud clock selection
	// Pure mux: the serial port sees the chosen overflow in the same cycle
	wire rx_pick = ctrl_q[`TFBS_RXSEL_BIT] ? TMR.t2_ovf : TMR.t1_ovf;
	wire tx_pick = ctrl_q[`TFBS_TXSEL_BIT] ? TMR.t2_ovf : TMR.t1_ovf;

	// ==========================================
	// Interrupts
	// Event flag interrupts only outside up/down mode, where it is a 17th count bit
	wire ext_irq  = ctrl_q[`TFBS_EXT_BIT] & ~TMR.updown_mode;
	wire flag_irq = ctrl_q[`TFBS_OVF_BIT] | ext_irq;
	wire ev_irq   = |(stat_q & ien_q);

	// ==========================================
	// Outputs
	assign HRDATA    = rdata_q;
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;
	assign BAUD      = {rx_pick, tx_pick, trig_act};
	assign T2_IRQ    = T2_IRQ_EN & flag_irq;
	assign IRQ       = ev_irq;
endmodule

// file: pkg/tfbs_consts.svh
`ifndef TFBS_CONSTS_SVH
`define TFBS_CONSTS_SVH

// ==========================================
// Register offsets (byte addresses)
`define TFBS_CTRL_OFS   12'h000
`define TFBS_STAT_OFS   12'h004
`define TFBS_CLR_OFS    12'h008
`define TFBS_IEN_OFS    12'h00C
`define TFBS_ADDR_W     12

// ==========================================
// Control register fields
`define TFBS_OVF_BIT    7
`define TFBS_EXT_BIT    6
`define TFBS_RXSEL_BIT  5
`define TFBS_TXSEL_BIT  4
`define TFBS_PINEN_BIT  3
`define TFBS_CTRL_RST   8'h00

// ==========================================
// Event status bits
`define TFBS_EV_OVF     0
`define TFBS_EV_EXT     1
`define TFBS_EV_W       2
`define TFBS_EV_RST     2'h0
`endif

// file: pkg/tfbs_pkg.sv
package tfbs_pkg;
	typedef struct packed {
		logic t1_ovf;
		logic t2_ovf;
		logic t2_unf;
		logic updown_mode;
		logic trig_fall;
	} tfbs_tmr_t;

	typedef struct packed {
		logic rx_baud;
		logic tx_baud;
		logic trig_act;
	} tfbs_out_t;

	typedef enum logic [1:0] {
		TFBS_ADDR,
		TFBS_DATA
	} tfbs_phase_t;
endpackage

// file: sim/tb.sv
`timescale 1ns/100ps
`include "tfbs_consts.svh"
module tb;
	import tfbs_pkg::*;
	logic        CORE_CLK = 0, NRST = 0, HSEL = 0, HWRITE = 0, T2_IRQ_EN = 0, HREADYOUT, HRESP, T2_IRQ, IRQ, u;
	logic [1:0]  HTRANS = 0;
	logic [2:0]  HSIZE = 3'h2;
	logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, r;
	logic [7:0]  c, e, rx_n, tx_n, rx_e = 0, tx_e = 0;
	tfbs_tmr_t   TMR = 0;
	tfbs_out_t   BAUD;
	int          k, n_mismatch = 0, check_count = 0;
	wire         HREADY = HREADYOUT;
	tfbs_top dut (.*);
	tfbs_sport_model sport (.clk(CORE_CLK), .baud(BAUD), .rx_n, .tx_n);
	initial forever #12.5 CORE_CLK = ~CORE_CLK;
	function automatic logic [7:0] exp_ctrl(logic [7:0] c, int k, logic u);
		logic b = c[5] | c[4];
		return {c[7] | !b & k inside {1, 2}, c[6] ^ u & k inside {1, 2} | !u & !b & c[3] & k == 3, c[5:3], 3'h0};
	endfunction
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] x, logic [31:0] s);
		check_count++;
		if (s !== x) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic wt;
		int i = 0;
		do @(posedge CORE_CLK); while (HREADYOUT !== 1 && ++i < 20);
		if (i > 19) begin
			n_mismatch++;
			final_report;
		end
	endtask
	task automatic bus(logic w, logic [31:0] a, logic [7:0] d);
		HSEL <= 1; HTRANS <= 2'h2; HADDR <= a; HWRITE <= w;
		wt;
		HSEL <= 0; HTRANS <= 0; HWDATA <= {24'h0, d};
		wt;
		r = HRDATA;
		chk("hresp", 0, HRESP);
	endtask
	initial begin
		void'($urandom(40));
		repeat (4) @(posedge CORE_CLK);
		NRST <= 1;
		bus(0, `TFBS_CTRL_OFS, 0);
		chk("ctrl", `TFBS_CTRL_RST, r);
		for (int i = 0; i < 200; i++) begin
			// Corners first: trigger taken, trigger blocked, overflow hidden, toggle
			c = i < 4 ? 8'(32'hC0302808 >> 8 * i) : 8'($urandom) & 8'hF8;
			k = i < 4 ? (8'h5F >> 2 * i) & 3 : $urandom % 4;
			u = i == 3 || k == 2 || i > 3 && $urandom % 2;
			T2_IRQ_EN <= i < 4 || $urandom % 2;
			TMR <= {3'h0, u, 1'h0};
			bus(1, `TFBS_CTRL_OFS, c);
			TMR <= TMR | 5'h10 >> k + (k > 2);
			e = exp_ctrl(c, k, u);
			rx_e += c[5] ? k == 1 : k == 0;
			tx_e += c[4] ? k == 1 : k == 0;
			@(posedge CORE_CLK);
			TMR <= TMR & 5'h02;
			bus(0, `TFBS_CTRL_OFS, 0);
			chk("ctrl", e, r);
			chk("t2 irq", T2_IRQ_EN & (e[7] | e[6] & ~u), T2_IRQ);
			chk("baud", {rx_e, tx_e}, {rx_n, tx_n});
		end
		TMR <= 0;
		bus(1, `TFBS_CLR_OFS, 3);
		bus(1, `TFBS_IEN_OFS, 1);
		bus(1, `TFBS_CTRL_OFS, 0);
		TMR <= 5'h08;
		repeat (2) @(posedge CORE_CLK);
		TMR <= 0;
		chk("irq", 1, IRQ);
		bus(1, `TFBS_IEN_OFS, 0);
		@(posedge CORE_CLK);
		chk("irq", 0, IRQ);
		bus(1, `TFBS_IEN_OFS, 1);
		bus(1, `TFBS_CLR_OFS, 1);
		bus(0, `TFBS_STAT_OFS, 0);
		chk("stat", 0, r);
		chk("irq", 0, IRQ);
		bus(0, 32'h10, 0);
		chk("hole", 0, r);
		final_report;
	end
endmodule

// file: sim/tfbs_props.sv
`timescale 1ns/100ps
// ==========
// Port checks
module tfbs_props (
	input wire logic                CORE_CLK,
	input wire logic                NRST,
	input wire logic                HSEL,
	input wire tfbs_pkg::tfbs_tmr_t TMR,
	input wire logic                T2_IRQ_EN,
	input wire tfbs_pkg::tfbs_out_t BAUD,
	input wire logic                T2_IRQ
);
	import tfbs_pkg::*;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	// Second timer alone, so the baud mux shows the selects
	wire t2 = TMR.t2_ovf & ~TMR.t1_ovf;
	rx_src_a: assert property (BAUD.rx_baud |-> TMR.t1_ovf || TMR.t2_ovf) else $error("rx");
	tx_src_a: assert property (BAUD.tx_baud |-> TMR.t1_ovf || TMR.t2_ovf) else $error("tx");
	trig_gate_a: assert property (BAUD.trig_act |-> TMR.trig_fall && !TMR.updown_mode) else $error("trig");
	irq_gate_a: assert property (T2_IRQ |-> T2_IRQ_EN) else $error("irq");
	trig_set_a: assert property (BAUD.trig_act |=> T2_IRQ || !T2_IRQ_EN || $rose(TMR.updown_mode))
		else $error("ext");
	ovf_set_a: assert property (t2 && !BAUD.rx_baud && !BAUD.tx_baud |=> T2_IRQ || !T2_IRQ_EN)
		else $error("ovf");
	ovf_block_a: assert property (t2 && (BAUD.rx_baud || BAUD.tx_baud) && !T2_IRQ && !HSEL && !$past(HSEL)
		|=> !T2_IRQ || $fell(TMR.updown_mode) || $rose(T2_IRQ_EN)) else $error("blk");
	flag_hold_a: assert property ($fell(T2_IRQ) |-> $fell(T2_IRQ_EN) || $rose(TMR.updown_mode) || $past(HSEL, 2))
		else $error("hold");
	cover property (BAUD.trig_act);
	cover property ($rose(T2_IRQ));
	cover property (t2 && BAUD.tx_baud);
endmodule
bind tfbs_top tfbs_props u_props (.CORE_CLK, .NRST, .HSEL, .TMR, .T2_IRQ_EN, .BAUD, .T2_IRQ);

// file: sim/tfbs_sport_model.sv
`timescale 1ns/100ps
// ==========
// Serial port end: counts baud ticks
module tfbs_sport_model (
	input wire logic                clk,
	input wire tfbs_pkg::tfbs_out_t baud,
	output logic [7:0]              rx_n,
	output logic [7:0]              tx_n
);
	import tfbs_pkg::*;
	initial {rx_n, tx_n} = '0;
	always @(posedge clk) {rx_n, tx_n} <= {rx_n + 8'(baud.rx_baud), tx_n + 8'(baud.tx_baud)};
endmodule
